// ---- logic/ssh_pkg.sv ----
package ssh_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_OFFSET = 8'h04;
  localparam logic [7:0] OFF_DIAG_SRC = 8'h08;
  localparam logic [7:0] OFF_DIAG_DISP = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_COMMAND = 8'h14;

  // Config register fields
  localparam int CFG_INPUT_LSB = 0;
  localparam int CFG_SOURCE_LSB = 8;
  localparam int CFG_LEVEL_BIT = 12;

  // Status register fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_ON_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_PINS_LSB = 4;
  localparam int ST_CMP_LSB = 16;

  // Command register bits
  localparam int CMD_IDENT_BIT = 0;
  localparam int CMD_RESTORE_BIT = 1;

  // Input configuration selecting 0-10 V start/stop
  localparam logic [7:0] INPUT_CFG_START_STOP = 8'h0C;

  // Control source codes
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERMINAL_STRIP = 2'h1;
  localparam logic [1:0] SRC_NETWORK = 2'h2;

  // Diagnostics source selections
  localparam logic [7:0] DIAG_SEL_COMPARED = 8'h0A;
  localparam logic [7:0] DIAG_SEL_STOP_THR = 8'h0B;
  localparam logic [7:0] DIAG_SEL_START_THR = 8'h0C;

  // Threshold defaults and limits in A/D counts
  localparam logic [10:0] STOP_THR_DEFAULT = 11'h014;
  localparam logic [10:0] START_THR_DEFAULT = 11'h021;
  localparam logic [10:0] STOP_THR_MIN = 11'h005;
  localparam logic [10:0] STOP_THR_MAX = 11'h3FF;
  localparam logic [10:0] START_THR_MIN = 11'h000;
  localparam logic [10:0] START_THR_MAX = 11'h7D0;

  // Offset correction limits and default
  localparam logic signed [10:0] OFFSET_MIN = -11'sh384;
  localparam logic signed [10:0] OFFSET_MAX = 11'sh384;
  localparam logic signed [10:0] OFFSET_DEFAULT = 11'sh000;

  // Terminal strip and keypad pin index
  localparam int PIN_FUNC_LOSS = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_START = 2;
  localparam int PIN_KEYPAD_STOP = 3;
  localparam int NUM_PINS = 4;

  // Whole block state
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pins;
    logic keypad_prev;
    logic [7:0] input_cfg;
    logic [1:0] terminal_strip_source;
    logic level_sense;
    logic signed [10:0] offset;
    logic [7:0] diag_src;
    logic [10:0] stop_thr;
    logic [10:0] start_thr;
    logic signed [11:0] compared;
    logic analog_on;
    logic rise;
    logic keypad_lock;
    logic run;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssh_state_t;

endpackage

// ---- logic/ssh_top.sv ----
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Contract
// - Input config 12 makes the analog input a 0-10 V start/stop source.
// - Start when compared value rises strictly above start threshold, permissives met.
// - Stop whenever compared value is at or below stop threshold.
// - Open terminal start input forces stop and holds it.
// - Start allowed only while terminal start input is closed.
// - Feature active only with control source set to terminal strip.
// - Closed function-loss, stop and start inputs are start permissives.
// - Terminal stop and function-loss inputs always stop the drive.
// - Compare offset-corrected value; diagnostics source 10 shows it.
// - Diagnostics source 11 maps stop threshold, 12 start threshold, read/write.
// - Power module identification loads thresholds 20 stop, 33 start.
// - Restore-defaults leaves both thresholds unchanged.
// - Stop threshold limited to 5..1023 counts.
// - Start threshold limited to 0..2000 counts.
// - Stop threshold above start threshold: stop wins.
// - Edge mode starts only on off-to-on transition with permissives met.
// - Level mode starts whenever input is on with permissives met.
// - Keypad stop in level mode needs a new off-to-on transition.
// - Analog input off stops and holds stopped in either mode.
// - Compared value is signed offset plus 10-bit A/D result.
// - Offset accepts -900..+900 counts.
module ssh_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // A/D converter, same clock
  input wire logic [9:0] adc_data,
  input wire logic adc_valid,
  // Terminal strip and keypad pins, high means closed or pressed
  input wire logic ts_func_loss_closed,
  input wire logic ts_stop_closed,
  input wire logic ts_start_closed,
  input wire logic keypad_stop,
  // Start/stop result
  output logic run_cmd,
  output logic analog_on
);

  ssh_pkg::ssh_state_t s_q;
  ssh_pkg::ssh_state_t s_d;

  // Saturate an unsigned write to a threshold window
  function automatic logic [10:0] clamp_thr(input logic [15:0] v, input logic [10:0] lo,
                                            input logic [10:0] hi);
    logic [10:0] r;
    if (v < {5'h00, lo}) begin
      r = lo;
    end else if (v > {5'h00, hi}) begin
      r = hi;
    end else begin
      r = v[10:0];
    end
    return r;
  endfunction

  // Saturate a signed write to the offset window
  function automatic logic signed [10:0] clamp_off(input logic signed [15:0] v);
    logic signed [10:0] r;
    if (v < 16'(ssh_pkg::OFFSET_MIN)) begin
      r = ssh_pkg::OFFSET_MIN;
    end else if (v > 16'(ssh_pkg::OFFSET_MAX)) begin
      r = ssh_pkg::OFFSET_MAX;
    end else begin
      r = v[10:0];
    end
    return r;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [ssh_pkg::NUM_PINS-1:0] raw;
    logic [ssh_pkg::NUM_PINS-1:0] agree;
    logic keypad_press;
    logic active;
    logic permit;
    logic new_on;
    logic signed [11:0] sum;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rdata;
    logic [31:0] disp;
    raw = '0;
    agree = '0;
    keypad_press = 1'b0;
    active = 1'b0;
    permit = 1'b0;
    new_on = 1'b0;
    sum = '0;
    setup = 1'b0;
    access = 1'b0;
    mapped = 1'b0;
    rdata = '0;
    disp = '0;
    s_d = s_q;

    // Three-stage pin synchronisers; a change counts once stages two and three agree
    raw[ssh_pkg::PIN_FUNC_LOSS] = ts_func_loss_closed;
    raw[ssh_pkg::PIN_STOP] = ts_stop_closed;
    raw[ssh_pkg::PIN_START] = ts_start_closed;
    raw[ssh_pkg::PIN_KEYPAD_STOP] = keypad_stop;
    s_d.sync1 = raw;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    agree = ~(s_q.sync2 ^ s_q.sync3);
    s_d.pins = (agree & s_q.sync3) | (~agree & s_q.pins);

    // Keypad stop acts on the press, not while held
    keypad_press = s_q.pins[ssh_pkg::PIN_KEYPAD_STOP] & ~s_q.keypad_prev;
    s_d.keypad_prev = s_q.pins[ssh_pkg::PIN_KEYPAD_STOP];

    // Feature enable
    active = (s_q.input_cfg == ssh_pkg::INPUT_CFG_START_STOP) &&
             (s_q.terminal_strip_source == ssh_pkg::SRC_TERMINAL_STRIP);

    // All three terminal inputs must be closed to permit a start
    permit = active & s_q.pins[ssh_pkg::PIN_FUNC_LOSS]
                    & s_q.pins[ssh_pkg::PIN_STOP]
                    & s_q.pins[ssh_pkg::PIN_START];

    // Hysteresis evaluated only on a fresh sample, so noise between samples is ignored
    s_d.rise = 1'b0;
    if (adc_valid) begin
      sum = $signed({2'b00, adc_data}) + 12'(s_q.offset);
      // Stop check first so an inverted threshold pair still stops
      if (sum <= $signed({1'b0, s_q.stop_thr})) begin
        new_on = 1'b0;
      end else if (sum > $signed({1'b0, s_q.start_thr})) begin
        new_on = 1'b1;
      end else begin
        new_on = s_q.analog_on;
      end
      s_d.compared = sum;
      s_d.analog_on = new_on;
      s_d.rise = new_on & ~s_q.analog_on;
    end

    // Keypad lock blocks level restarts until the input goes off again
    if (keypad_press) begin
      s_d.keypad_lock = 1'b1;
    end else if (!s_q.analog_on) begin
      s_d.keypad_lock = 1'b0;
    end

    // Run command; every stop path outranks every start path
    if (!permit || !s_q.analog_on || keypad_press) begin
      s_d.run = 1'b0;
    end else if (s_q.rise) begin
      s_d.run = 1'b1;
    end else if (s_q.level_sense && !s_q.keypad_lock) begin
      s_d.run = 1'b1;
    end

    // Diagnostics display view
    case (s_q.diag_src)
      ssh_pkg::DIAG_SEL_COMPARED: disp = 32'(s_q.compared);
      ssh_pkg::DIAG_SEL_STOP_THR: disp = {21'h000000, s_q.stop_thr};
      ssh_pkg::DIAG_SEL_START_THR: disp = {21'h000000, s_q.start_thr};
      default: disp = '0;
    endcase

    // APB decode; answer registered in the setup cycle so pready is a flop
    setup = psel & ~penable;
    access = psel & penable & s_q.pready;
    case (paddr)
      ssh_pkg::OFF_CONFIG: begin
        mapped = 1'b1;
        rdata[ssh_pkg::CFG_INPUT_LSB +: 8] = s_q.input_cfg;
        rdata[ssh_pkg::CFG_SOURCE_LSB +: 2] = s_q.terminal_strip_source;
        rdata[ssh_pkg::CFG_LEVEL_BIT] = s_q.level_sense;
      end
      ssh_pkg::OFF_OFFSET: begin
        mapped = 1'b1;
        rdata = 32'(s_q.offset);
      end
      ssh_pkg::OFF_DIAG_SRC: begin
        mapped = 1'b1;
        rdata[7:0] = s_q.diag_src;
      end
      ssh_pkg::OFF_DIAG_DISP: begin
        mapped = 1'b1;
        rdata = disp;
      end
      ssh_pkg::OFF_STATUS: begin
        mapped = 1'b1;
        rdata[ssh_pkg::ST_RUN_BIT] = s_q.run;
        rdata[ssh_pkg::ST_ON_BIT] = s_q.analog_on;
        rdata[ssh_pkg::ST_LOCK_BIT] = s_q.keypad_lock;
        rdata[ssh_pkg::ST_ACTIVE_BIT] = active;
        rdata[ssh_pkg::ST_PINS_LSB +: ssh_pkg::NUM_PINS] = s_q.pins;
        rdata[ssh_pkg::ST_CMP_LSB +: 12] = s_q.compared;
      end
      ssh_pkg::OFF_COMMAND: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    if (setup) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~mapped;
      s_d.prdata = (pwrite || !mapped) ? 32'h00000000 : rdata;
    end else if (access) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
    end

    // Register writes land on the completing access edge only
    if (access && pwrite && mapped) begin
      case (paddr)
        ssh_pkg::OFF_CONFIG: begin
          s_d.input_cfg = pwdata[ssh_pkg::CFG_INPUT_LSB +: 8];
          s_d.terminal_strip_source = pwdata[ssh_pkg::CFG_SOURCE_LSB +: 2];
          s_d.level_sense = pwdata[ssh_pkg::CFG_LEVEL_BIT];
        end
        ssh_pkg::OFF_OFFSET: begin
          s_d.offset = clamp_off($signed(pwdata[15:0]));
        end
        ssh_pkg::OFF_DIAG_SRC: begin
          s_d.diag_src = pwdata[7:0];
        end
        ssh_pkg::OFF_DIAG_DISP: begin
          if (s_q.diag_src == ssh_pkg::DIAG_SEL_STOP_THR) begin
            s_d.stop_thr = clamp_thr(pwdata[15:0], ssh_pkg::STOP_THR_MIN,
                                     ssh_pkg::STOP_THR_MAX);
          end else if (s_q.diag_src == ssh_pkg::DIAG_SEL_START_THR) begin
            s_d.start_thr = clamp_thr(pwdata[15:0], ssh_pkg::START_THR_MIN,
                                      ssh_pkg::START_THR_MAX);
          end
        end
        ssh_pkg::OFF_COMMAND: begin
          // Restore defaults resets settings but deliberately spares thresholds
          if (pwdata[ssh_pkg::CMD_RESTORE_BIT]) begin
            s_d.input_cfg = '0;
            s_d.terminal_strip_source = ssh_pkg::SRC_KEYPAD;
            s_d.level_sense = 1'b0;
            s_d.offset = ssh_pkg::OFFSET_DEFAULT;
            s_d.diag_src = '0;
          end
          // Identification still loads thresholds if both bits are written together
          if (pwdata[ssh_pkg::CMD_IDENT_BIT]) begin
            s_d.stop_thr = ssh_pkg::STOP_THR_DEFAULT;
            s_d.start_thr = ssh_pkg::START_THR_DEFAULT;
          end
        end
        default: begin
          s_d.diag_src = s_q.diag_src;
        end
      endcase
    end
  end

  // State register; thresholds come up at their defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.stop_thr <= ssh_pkg::STOP_THR_DEFAULT;
      s_q.start_thr <= ssh_pkg::START_THR_DEFAULT;
      s_q.offset <= ssh_pkg::OFFSET_DEFAULT;
      s_q.terminal_strip_source <= ssh_pkg::SRC_KEYPAD;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign run_cmd = s_q.run;
  assign analog_on = s_q.analog_on;

endmodule

// ---- tb/ssh_monitor.sv ----
`timescale 1ns/1ns
module ssh_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB answer side
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins, samples and result
  input wire logic ts_func_loss_closed,
  input wire logic ts_stop_closed,
  input wire logic ts_start_closed,
  input wire logic keypad_stop,
  input wire logic adc_valid,
  input wire logic run_cmd,
  input wire logic analog_on
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Bus answers stand one cycle only
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("data leak");
  // On-state moves only on a new sample
  a_on_sample: assert property ($changed(analog_on) |-> $past(adc_valid))
    else $error("on-state moved without sample");
  a_off_stop: assert property (!analog_on |=> !run_cmd) else $error("run while off");
  a_rise_on: assert property ($rose(run_cmd) |-> $past(analog_on)) else $error("bad start");
  // Pin path needs sync plus filter, so allow six edges
  a_start_open: assert property (!ts_start_closed [*6] |=> !run_cmd)
    else $error("run with start open");
  a_stop_open: assert property ((!ts_stop_closed || !ts_func_loss_closed) [*6] |=> !run_cmd)
    else $error("run with stop open");
  a_keypad_stop: assert property ($rose(keypad_stop) |-> ##[1:8] !run_cmd)
    else $error("keypad ignored");
endmodule
bind ssh_top ssh_monitor i_ssh_monitor (.clk, .nrst, .psel, .penable, .prdata, .pready,
  .pslverr, .ts_func_loss_closed, .ts_stop_closed, .ts_start_closed, .keypad_stop,
  .adc_valid, .run_cmd, .analog_on);

// ---- tb/ssh_operator.sv ----
`timescale 1ns/1ns
module ssh_operator (
  // Clock
  input wire logic clk,
  // Contacts and STOP key, high means closed or pressed
  output logic fl,
  output logic stp,
  output logic sta,
  output logic key
);
  // Contacts closed at power-up, key released
  initial {fl, stp, sta, key} = 4'hE;
  // Contacts move just after an edge; the block must sync them
  task automatic set(input logic [3:0] v);
    @(posedge clk);
    {fl, stp, sta, key} <= v;
  endtask
endmodule

// ---- tb/ssh_top_tb.sv ----
`timescale 1ns/1ns
module ssh_top_tb;
  // Bench signals
  logic clk, nrst, psel, penable, pwrite, adc_valid, on_m;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] adc_data, v;
  logic pready, pslverr, run_cmd, analog_on, fl, stp, sta, key;
  logic [64:0] q[$];
  logic [64:0] e;
  int failures = 0, checks = 0, cyc = 0, c, seed = 32'hd4023f14;
  localparam logic [7:0] CF = ssh_pkg::OFF_CONFIG, OF = ssh_pkg::OFF_OFFSET;
  localparam logic [7:0] DS = ssh_pkg::OFF_DIAG_SRC, DD = ssh_pkg::OFF_DIAG_DISP;
  localparam logic [7:0] ST = ssh_pkg::OFF_STATUS, CM = ssh_pkg::OFF_COMMAND;
  logic [7:0] sel [4] = '{8'h0B, 8'h0B, 8'h0C, 8'h0C};
  logic [31:0] wv [4] = '{32'h2, 32'h7D0, 32'hBB8, 32'h0};
  logic [31:0] ev [4] = '{32'h5, 32'h3FF, 32'h7D0, 32'h0};

  ssh_top i_ssh_top (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .adc_data, .adc_valid, .ts_func_loss_closed(fl),
    .ts_stop_closed(stp), .ts_start_closed(sta), .keypad_stop(key), .run_cmd, .analog_on);
  ssh_operator i_ssh_operator (.clk, .fl, .stp, .sta, .key);

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Oldest note against each bus answer
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk(prdata & e[63:32], e[31:0]);
      chk({31'h0, pslverr}, {31'h0, e[64]});
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      summarize();
    end
  end

  // Leading edge wait keeps back-to-back calls off one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, x,
    input logic er);
    q.push_back({er, m, x});
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0, m, x & m, 1'b0);
  endtask
  task automatic thr(input logic [7:0] s, input logic [31:0] x);
    wr(DS, {24'h0, s});
    rd(DD, x);
  endtask
  task automatic st(input logic r, input logic o);
    rd(ST, {30'h0, o, r}, 32'h3);
  endtask
  // One sample, then room for the run update
  task automatic smp(input logic [9:0] s);
    @(posedge clk);
    adc_data <= s;
    adc_valid <= 1;
    @(posedge clk);
    adc_valid <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pins(input logic [3:0] p);
    i_ssh_operator.set(p);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, adc_valid} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    adc_data = 10'h0;
    repeat (8) @(posedge clk);
    nrst <= 1;
    apb(1'b0, 8'h18, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    thr(8'h0B, 32'h14);
    thr(8'h0C, 32'h21);
    for (int i = 0; i < 4; i++) begin
      wr(DS, {24'h0, sel[i]});
      wr(DD, wv[i]);
      rd(DD, ev[i]);
    end
    wr(CM, 32'h2);
    thr(8'h0B, 32'h3FF);
    thr(8'h0C, 32'h0);
    wr(CM, 32'h1);
    thr(8'h0B, 32'h14);
    thr(8'h0C, 32'h21);
    wr(OF, 32'h3E8);
    rd(OF, 32'h384);
    wr(OF, 32'hFC18);
    rd(OF, 32'hFFFFFC7C);
    wr(OF, 32'hFFFD);
    $display("registers done");
    wr(CF, 32'h10C);
    on_m = 0;
    for (int i = 0; i < 24; i++) begin
      v = 10'($unsigned($random(seed))) & 10'h03F;
      c = int'(v) - 3;
      if (c <= 20) on_m = 0;
      else if (c > 33) on_m = 1;
      smp(v);
      rd(ST, {4'h0, 12'(c), 14'h0, on_m, 1'b0}, 32'h0FFF0002);
    end
    thr(8'h0A, 32'(c));
    $display("hysteresis done");
    smp(10'h0);
    st(1'b0, 1'b0);
    smp(10'h32);
    st(1'b1, 1'b1);
    pins(4'hC);
    st(1'b0, 1'b1);
    pins(4'hE);
    st(1'b0, 1'b1);
    smp(10'h0);
    smp(10'h32);
    st(1'b1, 1'b1);
    pins(4'hA);
    st(1'b0, 1'b1);
    pins(4'hE);
    $display("edge mode done");
    wr(CF, 32'h110C);
    st(1'b1, 1'b1);
    pins(4'hF);
    pins(4'hE);
    rd(ST, 32'h6, 32'h7);
    smp(10'h32);
    rd(ST, 32'h6, 32'h7);
    smp(10'h0);
    smp(10'h32);
    st(1'b1, 1'b1);
    pins(4'hC);
    st(1'b0, 1'b1);
    pins(4'hE);
    st(1'b1, 1'b1);
    smp(10'hA);
    st(1'b0, 1'b0);
    wr(DS, 32'hB);
    wr(DD, 32'h64);
    wr(DS, 32'hC);
    wr(DD, 32'h32);
    smp(10'h50);
    st(1'b0, 1'b0);
    smp(10'h6E);
    st(1'b1, 1'b1);
    $display("level mode done");
    wr(CF, 32'h100C);
    rd(ST, 32'h2, 32'hB);
    wr(CF, 32'h110B);
    rd(ST, 32'h2, 32'hB);
    $display("source and config done");
    summarize();
  end
endmodule
